//--- rtl/stop_wake_pkg.sv
package stop_wake_pkg;

   localparam int          ADDR_W                  = 12;
   localparam int          DATA_W                  = 32;
   localparam int          SEL_W                   = 3;
   localparam int          EXP_W                   = 6;
   localparam int          NUM_EXT_IRQ             = 7;
   localparam int          NUM_CSI                 = 5;

   localparam logic [11:0] ADDR_POWER_SAVE_MODE    = 12'h000;
   localparam logic [11:0] ADDR_POWER_SAVE_CONTROL = 12'h004;
   localparam logic [11:0] ADDR_STAB_TIME_SELECT   = 12'h008;
   localparam logic [11:0] ADDR_CLOCK_CONFIG       = 12'h00c;
   localparam logic [11:0] ADDR_WAKE_MASK          = 12'h010;
   localparam logic [11:0] ADDR_STATUS             = 12'h014;

   localparam int          BIT_STOP_VS_IDLE        = 0;
   localparam int          BIT_STANDBY_TRIGGER     = 0;
   localparam int          BIT_WDT_RESTART         = 1;
   localparam int          CFG_SUBCLOCK_USED       = 0;
   localparam int          CFG_RTC_ON_SUBCLOCK     = 1;
   localparam int          CFG_WDT_ENABLE          = 2;
   localparam int          CFG_CSI_LSB             = 3;
   localparam int          STATUS_RESET_WAKE       = 2;

   localparam logic [2:0]  STAB_SEL_RESET          = 3'h5;

   typedef enum logic [1:0] {
      ST_RUN   = 2'b00,
      ST_STOP  = 2'b01,
      ST_STAB  = 2'b10,
      ST_RESET = 2'b11
   } state_e;

endpackage

//--- rtl/wdt_counter.sv
`timescale 1ns/1ps
module wdt_counter
   import stop_wake_pkg::*;
#(
   parameter int CNT_W = 22
) (
   input  wire logic             pclk,
   input  wire logic             presetn,
   input  wire logic             clear,
   input  wire logic             enable,
   input  wire logic [EXP_W-1:0] exponent,
   output logic                  overflow
);

   logic [CNT_W-1:0] count_reg;
   logic [CNT_W-1:0] count_next;
   logic             ovf_reg;
   logic             ovf_next;
   logic [CNT_W-1:0] terminal;

   // The count wraps after two to the power of exponent enabled cycles.
   always_comb begin
      terminal   = (CNT_W'(1) << exponent) - CNT_W'(1);
      count_next = count_reg;
      ovf_next   = 1'b0;
      if (clear) begin
         count_next = '0;
      end else if (enable) begin
         if (count_reg == terminal) begin
            count_next = '0;
            ovf_next   = 1'b1;
         end else begin
            count_next = count_reg + CNT_W'(1);
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count_reg <= '0;
         ovf_reg   <= 1'b0;
      end else begin
         count_reg <= count_next;
         ovf_reg   <= ovf_next;
      end
   end

   assign overflow = ovf_reg;

endmodule // wdt_counter

//--- rtl/stop_wake_sequencer.sv
// Summary of operation
// - Writing standby trigger with stop selected in normal operation enters stop state.
// - Stop ends on NMI, unmasked external or running-peripheral interrupt, or reset pin.
// - After release, oscillation stabilization time elapses before normal operation resumes.
// - Reset pin release from stop spends one more cycle in the reset state, then runs the ordinary reset sequence.
// - In stop the real-time counter runs only on a used, selected subclock.
// - In stop a serial channel runs only with its external clock selected.
// - In stop port outputs and configuration hold their pre-stop values.
// - In stop CPU registers, flags and RAM contents are preserved.
// - Interrupt release waits only the selected stabilization interval.
// - Reset pin release uses the default select, two to the nineteenth clocks.
// - The stabilization wait is counted by the shared watchdog counter.
// - The stabilization wait ends at the watchdog counter overflow.
`timescale 1ns/1ps
module stop_wake_sequencer
   import stop_wake_pkg::*;
#(
   parameter int STAB_RESET_EXP = 19,
   parameter int N_EXT          = NUM_EXT_IRQ,
   parameter int N_CSI          = NUM_CSI
) (
   input  wire logic              pclk,
   input  wire logic              presetn,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [ADDR_W-1:0] paddr,
   input  wire logic [DATA_W-1:0] pwdata,
   output logic [DATA_W-1:0]      prdata,
   output logic                   pready,
   output logic                   pslverr,
   input  wire logic              reset_pin_n,
   input  wire logic              nmi,
   input  wire logic [N_EXT-1:0]  ext_irq_pins,
   input  wire logic              rtc_irq,
   input  wire logic [N_CSI-1:0]  csi_irq,
   output logic                   main_osc_en,
   output logic                   cpu_clk_en,
   output logic                   periph_clk_en,
   output logic                   rtc_clk_en,
   output logic [N_CSI-1:0]       csi_clk_en,
   output logic                   port_hold,
   output logic                   data_retain,
   output logic                   cpu_reset_n,
   output logic                   wdt_overflow,
   output logic                   stop_active
);

   localparam int CNT_W  = STAB_RESET_EXP + 3;
   localparam int CFG_W  = CFG_CSI_LSB + N_CSI;
   localparam int MASK_W = N_EXT + 1 + N_CSI;

   function automatic logic [EXP_W-1:0] stab_exp(input logic [SEL_W-1:0] sel);
      return EXP_W'(STAB_RESET_EXP - int'(STAB_SEL_RESET) + int'(sel));
   endfunction

   state_e             state_reg;
   state_e             state_next;
   logic               stop_vs_idle_select_reg;
   logic               stop_vs_idle_select_next;
   logic [SEL_W-1:0]   stab_time_select_reg;
   logic [SEL_W-1:0]   stab_time_select_next;
   logic [CFG_W-1:0]   cfg_reg;
   logic [CFG_W-1:0]   cfg_next;
   logic [MASK_W-1:0]  mask_reg;
   logic [MASK_W-1:0]  mask_next;
   logic               reset_wake_reg;
   logic               reset_wake_next;
   logic               pready_reg;
   logic               pready_next;
   logic               pslverr_reg;
   logic               pslverr_next;
   logic [DATA_W-1:0]  prdata_reg;
   logic [DATA_W-1:0]  prdata_next;
   logic               osc_reg;
   logic               osc_next;
   logic               cpu_en_reg;
   logic               cpu_en_next;
   logic               rtc_en_reg;
   logic               rtc_en_next;
   logic [N_CSI-1:0]   csi_en_reg;
   logic [N_CSI-1:0]   csi_en_next;
   logic               hold_reg;
   logic               hold_next;
   logic               cpu_rst_n_reg;
   logic               cpu_rst_n_next;
   logic               wdt_ovf_reg;
   logic               wdt_ovf_next;
   logic               stop_reg;
   logic               stop_next;
   logic               xfer;
   logic               wr_ok;
   logic               standby_write;
   logic               wdt_restart;
   logic               rtc_keep;
   logic [N_CSI-1:0]   csi_sel;
   logic               wake;
   logic               low_power;
   logic               cnt_clear;
   logic               cnt_en;
   logic               cnt_ovf;
   logic [CNT_W-1:0]   stab_len;

   always_comb begin
      xfer          = psel && penable && pready_reg;
      wr_ok         = xfer && pwrite && (state_reg == ST_RUN) && reset_pin_n;
      standby_write = wr_ok && (paddr == ADDR_POWER_SAVE_CONTROL)
                      && pwdata[BIT_STANDBY_TRIGGER] && stop_vs_idle_select_reg;
      wdt_restart   = wr_ok && (paddr == ADDR_POWER_SAVE_CONTROL) && pwdata[BIT_WDT_RESTART];
      rtc_keep      = cfg_reg[CFG_SUBCLOCK_USED] && cfg_reg[CFG_RTC_ON_SUBCLOCK];
      csi_sel       = cfg_reg[CFG_CSI_LSB +: N_CSI];
      wake          = nmi
                      || |(ext_irq_pins & ~mask_reg[N_EXT-1:0])
                      || (rtc_irq && rtc_keep && !mask_reg[N_EXT])
                      || |(csi_irq & csi_sel & ~mask_reg[N_EXT+1 +: N_CSI]);
   end

   // Sequencer and software-visible registers.
   always_comb begin
      state_next               = state_reg;
      stop_vs_idle_select_next = stop_vs_idle_select_reg;
      stab_time_select_next    = stab_time_select_reg;
      cfg_next                 = cfg_reg;
      mask_next                = mask_reg;
      reset_wake_next          = reset_wake_reg;
      if (wr_ok) begin
         if (paddr == ADDR_POWER_SAVE_MODE) begin
            stop_vs_idle_select_next = pwdata[BIT_STOP_VS_IDLE];
         end else if (paddr == ADDR_STAB_TIME_SELECT) begin
            stab_time_select_next = pwdata[SEL_W-1:0];
         end else if (paddr == ADDR_CLOCK_CONFIG) begin
            cfg_next = pwdata[CFG_W-1:0];
         end else if (paddr == ADDR_WAKE_MASK) begin
            mask_next = pwdata[MASK_W-1:0];
         end
      end
      case (state_reg)
         ST_RUN: begin
            if (standby_write) begin
               state_next      = ST_STOP;
               reset_wake_next = 1'b0;
            end
         end
         ST_STOP: begin
            if (wake) begin
               state_next      = ST_STAB;
               reset_wake_next = 1'b0;
            end
         end
         ST_STAB: begin
            if (cnt_ovf) begin
               state_next = ST_RUN;
            end
         end
         default: begin
            state_next = ST_STAB;
         end
      endcase
      if (!reset_pin_n) begin
         state_next               = ST_RESET;
         stop_vs_idle_select_next = 1'b0;
         stab_time_select_next    = STAB_SEL_RESET;
         cfg_next                 = '0;
         mask_next                = '1;
         reset_wake_next          = 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg               <= ST_STAB;
         stop_vs_idle_select_reg <= 1'b0;
         stab_time_select_reg    <= STAB_SEL_RESET;
         cfg_reg                 <= '0;
         mask_reg                <= '1;
         reset_wake_reg          <= 1'b1;
      end else begin
         state_reg               <= state_next;
         stop_vs_idle_select_reg <= stop_vs_idle_select_next;
         stab_time_select_reg    <= stab_time_select_next;
         cfg_reg                 <= cfg_next;
         mask_reg                <= mask_next;
         reset_wake_reg          <= reset_wake_next;
      end
   end

   // The stabilization wait and the watchdog share one counter.
   always_comb begin
      cnt_clear = !reset_pin_n || wdt_restart
                  || (state_next == ST_STAB && state_reg != ST_STAB);
      cnt_en    = (state_reg == ST_STAB) || (state_reg == ST_RUN && cfg_reg[CFG_WDT_ENABLE]);
   end

   wdt_counter #(
      .CNT_W (CNT_W)
   ) u_wdt_counter (
      .pclk     (pclk),
      .presetn  (presetn),
      .clear    (cnt_clear),
      .enable   (cnt_en),
      .exponent (stab_exp(stab_time_select_reg)),
      .overflow (cnt_ovf)
   );

   // Clock gating and retention controls follow the next state.
   always_comb begin
      low_power      = (state_next == ST_STOP) || (state_next == ST_STAB);
      osc_next       = (state_next != ST_STOP);
      cpu_en_next    = (state_next == ST_RUN);
      rtc_en_next    = (state_next == ST_RUN) || (low_power && rtc_keep);
      csi_en_next    = {N_CSI{state_next == ST_RUN}} | ({N_CSI{low_power}} & csi_sel);
      hold_next      = low_power && !reset_wake_next;
      cpu_rst_n_next = !(state_next == ST_RESET || (state_next == ST_STAB && reset_wake_next));
      wdt_ovf_next   = cnt_ovf && (state_reg == ST_RUN);
      stop_next      = (state_next == ST_STOP);
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         osc_reg       <= 1'b1;
         cpu_en_reg    <= 1'b0;
         rtc_en_reg    <= 1'b0;
         csi_en_reg    <= '0;
         hold_reg      <= 1'b0;
         cpu_rst_n_reg <= 1'b0;
         wdt_ovf_reg   <= 1'b0;
         stop_reg      <= 1'b0;
      end else begin
         osc_reg       <= osc_next;
         cpu_en_reg    <= cpu_en_next;
         rtc_en_reg    <= rtc_en_next;
         csi_en_reg    <= csi_en_next;
         hold_reg      <= hold_next;
         cpu_rst_n_reg <= cpu_rst_n_next;
         wdt_ovf_reg   <= wdt_ovf_next;
         stop_reg      <= stop_next;
      end
   end

   // Bus slave with one wait state.
   always_comb begin
      pready_next  = psel && penable && !pready_reg;
      pslverr_next = 1'b0;
      prdata_next  = prdata_reg;
      if (pready_next) begin
         prdata_next = '0;
         if (paddr == ADDR_POWER_SAVE_MODE) begin
            prdata_next[BIT_STOP_VS_IDLE] = stop_vs_idle_select_reg;
         end else if (paddr == ADDR_POWER_SAVE_CONTROL) begin
            prdata_next = '0;
         end else if (paddr == ADDR_STAB_TIME_SELECT) begin
            prdata_next[SEL_W-1:0] = stab_time_select_reg;
         end else if (paddr == ADDR_CLOCK_CONFIG) begin
            prdata_next[CFG_W-1:0] = cfg_reg;
         end else if (paddr == ADDR_WAKE_MASK) begin
            prdata_next[MASK_W-1:0] = mask_reg;
         end else if (paddr == ADDR_STATUS) begin
            prdata_next[1:0]               = state_reg;
            prdata_next[STATUS_RESET_WAKE] = reset_wake_reg;
         end else begin
            pslverr_next = 1'b1;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_reg  <= 1'b0;
         pslverr_reg <= 1'b0;
         prdata_reg  <= '0;
      end else begin
         pready_reg  <= pready_next;
         pslverr_reg <= pslverr_next;
         prdata_reg  <= prdata_next;
      end
   end

   assign prdata        = prdata_reg;
   assign pready        = pready_reg;
   assign pslverr       = pslverr_reg;
   assign main_osc_en   = osc_reg;
   assign cpu_clk_en    = cpu_en_reg;
   assign periph_clk_en = cpu_en_reg;
   assign rtc_clk_en    = rtc_en_reg;
   assign csi_clk_en    = csi_en_reg;
   assign port_hold     = hold_reg;
   assign data_retain   = hold_reg;
   assign cpu_reset_n   = cpu_rst_n_reg;
   assign wdt_overflow  = wdt_ovf_reg;
   assign stop_active   = stop_reg;

   // Cycles spent in the stabilization state, for checking only.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stab_len <= '0;
      end else begin
         stab_len <= (state_reg == ST_STAB && state_next == ST_STAB)
                     ? stab_len + CNT_W'(1) : '0;
      end
   end

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence pin_pulse_s;
      !reset_pin_n ##1 reset_pin_n;
   endsequence

   sequence reset_restart_s;
      state_reg == ST_RESET ##1 (state_reg == ST_STAB && !cpu_reset_n
                                 && stab_time_select_reg == STAB_SEL_RESET);
   endsequence

   a_stop_entry:
      assert property ((standby_write && reset_pin_n) |=> state_reg == ST_STOP)
      else $error("standby trigger did not enter stop");
   a_wake_release:
      assert property ((state_reg == ST_STOP && wake && reset_pin_n) |=> state_reg == ST_STAB)
      else $error("wake request did not release stop");
   a_stab_before_run:
      assert property ((state_reg == ST_RUN && $past(state_reg) != ST_RUN)
                       |-> $past(state_reg) == ST_STAB)
      else $error("normal operation resumed without stabilization");
   a_reset_pin_restart:
      assert property (pin_pulse_s |-> reset_restart_s)
      else $error("reset pin release did not run reset sequence");
   a_rtc_stop_clock:
      assert property (state_reg == ST_STOP |-> rtc_clk_en == rtc_keep)
      else $error("real-time counter clock wrong in stop");
   a_csi_stop_clock:
      assert property (state_reg == ST_STOP |-> csi_clk_en == csi_sel)
      else $error("serial channel clock wrong in stop");
   a_ports_held:
      assert property ((state_reg == ST_STOP && $past(state_reg) == ST_STOP)
                       |-> port_hold && $stable(cfg_reg) && $stable(mask_reg))
      else $error("port state not held in stop");
   a_data_kept:
      assert property (state_reg == ST_STOP |-> data_retain && $stable(stab_time_select_reg))
      else $error("internal data not retained in stop");
   a_stab_length:
      assert property ((state_reg == ST_RUN && $past(state_reg) == ST_STAB)
                       |-> $past(stab_len) == (CNT_W'(1) << stab_exp(stab_time_select_reg)))
      else $error("stabilization length differs from selection");
   a_reset_default:
      assert property ((state_reg == ST_STAB && reset_wake_reg)
                       |-> stab_exp(stab_time_select_reg) == EXP_W'(STAB_RESET_EXP))
      else $error("reset release not using default stabilization");
   a_shared_counter:
      assert property ((state_reg == ST_RUN && $past(state_reg) == ST_STAB) |-> $past(cnt_ovf))
      else $error("stabilization not ended by shared counter");
   a_ovf_ends_stab:
      assert property ((state_reg == ST_STAB && cnt_ovf && reset_pin_n) |=> state_reg == ST_RUN)
      else $error("counter overflow did not end stabilization");
   a_clocks_gated:
      assert property (state_reg == ST_STOP |-> !main_osc_en && !cpu_clk_en && !periph_clk_en)
      else $error("clocks not gated in stop");

endmodule // stop_wake_sequencer

//--- sim/irq_reset_source.sv
`timescale 1ns/1ps
module irq_reset_source
   import stop_wake_pkg::*;
(
   input  wire logic                   pclk,
   input  wire logic                   fire,
   input  wire logic [2:0]             kind,
   input  wire logic [2:0]             idx,
   input  wire logic [2:0]             lag,
   output logic                        busy,
   output logic                        reset_pin_n,
   output logic                        nmi,
   output logic [NUM_EXT_IRQ-1:0]      ext_irq_pins,
   output logic                        rtc_irq,
   output logic [NUM_CSI-1:0]          csi_irq
);
   int wait_cnt;
   int hold_cnt;

   initial begin
      busy         = 1'b0;
      reset_pin_n  = 1'b1;
      nmi          = 1'b0;
      ext_irq_pins = '0;
      rtc_irq      = 1'b0;
      csi_irq      = '0;
   end

   // A request waits lag cycles, then one source stays asserted for four cycles.
   always @(posedge pclk) begin
      if (fire && !busy) begin
         busy     <= 1'b1;
         wait_cnt <= int'(lag);
         hold_cnt <= 4;
      end else if (busy && wait_cnt > 0) begin
         wait_cnt <= wait_cnt - 1;
      end else if (busy && hold_cnt > 0) begin
         hold_cnt     <= hold_cnt - 1;
         reset_pin_n  <= (kind != 3'h4);
         nmi          <= (kind == 3'h0);
         ext_irq_pins <= (kind == 3'h1) ? NUM_EXT_IRQ'(1 << idx) : '0;
         rtc_irq      <= (kind == 3'h2);
         csi_irq      <= (kind == 3'h3) ? NUM_CSI'(1 << idx) : '0;
      end else if (busy) begin
         busy         <= 1'b0;
         reset_pin_n  <= 1'b1;
         nmi          <= 1'b0;
         ext_irq_pins <= '0;
         rtc_irq      <= 1'b0;
         csi_irq      <= '0;
      end
   end
endmodule // irq_reset_source

//--- sim/tb_stop_wake_sequencer.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin num_errors++; \
   $display("ERROR %s expected %0h seen %0h", nm, e, g); end end
module tb_stop_wake_sequencer;
   import stop_wake_pkg::*;
   localparam int E = 8;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [ADDR_W-1:0] paddr;
   logic [DATA_W-1:0] pwdata, prdata, d;
   logic reset_pin_n, nmi, rtc_irq, main_osc_en, cpu_clk_en, periph_clk_en, rtc_clk_en;
   logic port_hold, data_retain, cpu_reset_n, wdt_overflow, stop_active, er;
   logic [NUM_EXT_IRQ-1:0] ext_irq_pins;
   logic [NUM_CSI-1:0] csi_irq, csi_clk_en;
   logic fire, busy;
   logic [2:0] kind, idx, lag;
   logic [31:0] seed = 32'hb502;
   int num_errors, num_checks, stab_cnt, stab_len, wdt_gap, wdt_last, cyc;
   int cfg, sel, mask, k, i;
   bit w;

   stop_wake_sequencer #(.STAB_RESET_EXP(E)) uut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .reset_pin_n(reset_pin_n), .nmi(nmi), .ext_irq_pins(ext_irq_pins), .rtc_irq(rtc_irq),
      .csi_irq(csi_irq), .main_osc_en(main_osc_en), .cpu_clk_en(cpu_clk_en),
      .periph_clk_en(periph_clk_en), .rtc_clk_en(rtc_clk_en), .csi_clk_en(csi_clk_en),
      .port_hold(port_hold), .data_retain(data_retain), .cpu_reset_n(cpu_reset_n),
      .wdt_overflow(wdt_overflow), .stop_active(stop_active));

   irq_reset_source src (
      .pclk(pclk), .fire(fire), .kind(kind), .idx(idx), .lag(lag), .busy(busy),
      .reset_pin_n(reset_pin_n), .nmi(nmi), .ext_irq_pins(ext_irq_pins),
      .rtc_irq(rtc_irq), .csi_irq(csi_irq));

   initial begin
      pclk = 1'b0;
      forever #25 pclk = ~pclk;
   end

   // Measures stabilization lengths and watchdog overflow spacing.
   always @(negedge pclk) begin
      cyc++;
      if (wdt_overflow === 1'b1) begin
         wdt_gap = cyc - wdt_last;
         wdt_last = cyc;
      end
      if (cpu_clk_en === 1'b1 && stab_cnt != 0) begin
         stab_len = stab_cnt;
         stab_cnt = 0;
      end else if (presetn && reset_pin_n && main_osc_en === 1'b1 && cpu_clk_en === 1'b0
                   && stop_active === 1'b0) begin
         stab_cnt++;
      end
   end

   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   function automatic bit wakes(int k, int i, int cfg, int mask);
      case (k)
         0: return 1'b1;
         1: return !mask[i];
         2: return cfg[0] && cfg[1] && !mask[7];
         default: return cfg[3+i] && !mask[8+i];
      endcase
   endfunction

   task automatic final_report();
      $display("checks %0d mismatches %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      d = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] v);
      apb(1'b1, a, v);
   endtask

   task automatic rd(input logic [11:0] a, input logic [31:0] e, input string nm);
      apb(1'b0, a, 32'h0);
      `CHK(nm, e, d)
   endtask

   task automatic pulse(input int kk, input int ii);
      @(posedge pclk);
      kind <= 3'(kk);
      idx <= 3'(ii);
      lag <= 3'(xs());
      fire <= 1'b1;
      @(posedge pclk);
      fire <= 1'b0;
      do begin
         @(posedge pclk);
      end while (busy !== 1'b0);
      @(negedge pclk);
   endtask

   task automatic wait_run(input int e, input string nm);
      while (cpu_clk_en !== 1'b1) begin
         @(negedge pclk);
      end
      @(negedge pclk);
      `CHK(nm, e, stab_len)
   endtask

   task automatic enter_stop();
      wr(ADDR_POWER_SAVE_MODE, 32'h1);
      wr(ADDR_POWER_SAVE_CONTROL, 32'h1);
      @(negedge pclk);
      `CHK("stop_active", 1'b1, stop_active)
      `CHK("main_osc_en", 1'b0, main_osc_en)
      `CHK("cpu_clk_en", 1'b0, cpu_clk_en)
      `CHK("periph_clk_en", 1'b0, periph_clk_en)
      `CHK("port_hold", 1'b1, port_hold)
      `CHK("data_retain", 1'b1, data_retain)
   endtask

   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = '0;
      pwdata = '0;
      fire = 1'b0;
      kind = '0;
      idx = '0;
      lag = '0;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      rd(ADDR_STATUS, 32'h6, "status stab");
      rd(ADDR_WAKE_MASK, 32'h1fff, "mask reset");
      rd(ADDR_STAB_TIME_SELECT, 32'(STAB_SEL_RESET), "sel reset");
      wr(ADDR_CLOCK_CONFIG, 32'hff);
      wait_run((1 << E) + 1, "power-on stab");
      rd(ADDR_CLOCK_CONFIG, 32'h0, "config kept");
      rd(ADDR_POWER_SAVE_CONTROL, 32'h0, "control reads zero");
      apb(1'b0, 12'h020, 32'h0);
      `CHK("unmapped pslverr", 1'b1, er)
      wr(ADDR_POWER_SAVE_CONTROL, 32'h1);
      @(negedge pclk);
      `CHK("idle select ignored", 1'b0, stop_active)
      $display("test reset and bus done");
      repeat (10) begin
         cfg = int'(xs() & 32'hfb);
         sel = int'(xs() & 32'h7);
         mask = int'(xs() & 32'h1fff);
         k = int'(xs() % 4);
         i = int'(xs() % ((k == 1) ? 7 : 5));
         w = wakes(k, i, cfg, mask);
         wr(ADDR_CLOCK_CONFIG, 32'(cfg));
         wr(ADDR_STAB_TIME_SELECT, 32'(sel));
         wr(ADDR_WAKE_MASK, 32'(mask));
         enter_stop();
         `CHK("rtc_clk_en", 1'(cfg[0] & cfg[1]), rtc_clk_en)
         `CHK("csi_clk_en", 5'(cfg >> 3), csi_clk_en)
         pulse(k, i);
         `CHK("wake decision", !w, stop_active)
         if (!w) pulse(0, 0);
         wait_run((1 << (E - 5 + sel)) + 1, "irq stab");
         `CHK("port released", 1'b0, port_hold)
      end
      $display("test interrupt wake done");
      wr(ADDR_STAB_TIME_SELECT, 32'h2);
      wr(ADDR_WAKE_MASK, 32'h0);
      enter_stop();
      pulse(4, 0);
      `CHK("cpu_reset_n", 1'b0, cpu_reset_n)
      wr(ADDR_CLOCK_CONFIG, 32'hff);
      wait_run((1 << E) + 2, "reset pin stab");
      `CHK("cpu_reset_n released", 1'b1, cpu_reset_n)
      rd(ADDR_STAB_TIME_SELECT, 32'(STAB_SEL_RESET), "sel default");
      rd(ADDR_WAKE_MASK, 32'h1fff, "mask default");
      rd(ADDR_CLOCK_CONFIG, 32'h0, "config default");
      rd(ADDR_STATUS, 32'h4, "reset wake status");
      $display("test reset pin wake done");
      wr(ADDR_STAB_TIME_SELECT, 32'h1);
      wr(ADDR_CLOCK_CONFIG, 32'h4);
      wdt_gap = 0;
      repeat (60) @(negedge pclk);
      `CHK("watchdog period", (1 << (E - 4)), wdt_gap)
      wr(ADDR_POWER_SAVE_CONTROL, 32'h2);
      repeat (2) @(negedge pclk);
      wdt_gap = 0;
      repeat (5) wr(ADDR_POWER_SAVE_CONTROL, 32'h2);
      `CHK("watchdog restart", 0, wdt_gap)
      $display("test watchdog done");
      final_report();
   end

   initial begin
      repeat (80000) @(posedge pclk);
      num_errors++;
      final_report();
   end
endmodule // tb_stop_wake_sequencer
